// file: shared/flag_mask_pkg.sv
package flag_mask_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_SLOTS = 5;
  localparam int FLAG_W = 40;
  localparam int EVT_W = 3;

  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_CDB_FW_STATE = 6'h1f;
  localparam logic [5:0] IDX_SUPPLY_TEMP = 6'h20;
  localparam logic [5:0] IDX_AUX_ONE_TWO = 6'h21;
  localparam logic [5:0] IDX_VENDOR_AUX_THREE = 6'h22;
  localparam logic [5:0] IDX_RESERVED = 6'h23;
  localparam logic [5:0] IDX_CUSTOM = 6'h24;
  localparam logic [5:0] IDX_EVT_STATUS = 6'h28;
  localparam logic [5:0] IDX_EVT_MASK = 6'h29;
  localparam logic [5:0] IDX_PENDING = 6'h2a;

  // mask slots in flag order: bytes 31, 32, 33, 34, 36
  localparam logic [5:0] SLOT_IDX [0:NUM_SLOTS-1] = '{IDX_CDB_FW_STATE, IDX_SUPPLY_TEMP,
    IDX_AUX_ONE_TWO, IDX_VENDOR_AUX_THREE, IDX_CUSTOM};
  localparam logic [7:0] WMASK_CDB_FW = 8'hc7;
  localparam logic [7:0] WMASK_FULL = 8'hff;
  localparam logic [7:0] SLOT_WMASK [0:NUM_SLOTS-1] = '{WMASK_CDB_FW, WMASK_FULL, WMASK_FULL,
    WMASK_FULL, WMASK_FULL};
  localparam logic [7:0] MASK_RESET = 8'h00;

  // byte 31 fields
  localparam int BIT_CMD_BLOCK_TWO_DONE = 7;
  localparam int BIT_CMD_BLOCK_ONE_DONE = 6;
  localparam int BIT_DATAPATH_FW_FAULT = 2;
  localparam int BIT_MODULE_FW_FAULT = 1;
  localparam int BIT_STATE_CHANGED = 0;
  // monitor groups: upper and lower nibble, each low warn, high warn, low alarm, high alarm
  localparam int GRP_UPPER = 4;
  localparam int GRP_LOWER = 0;
  localparam int OFS_LOW_WARN = 3;
  localparam int OFS_HIGH_WARN = 2;
  localparam int OFS_LOW_ALARM = 1;
  localparam int OFS_HIGH_ALARM = 0;

  // event status bits
  localparam int EVT_INTR_RISE = 0;
  localparam int EVT_INTR_FALL = 1;
  localparam int EVT_DECODE_ERR = 2;
  localparam logic [EVT_W-1:0] EVT_STATUS_RESET = 3'h0;
  localparam logic [EVT_W-1:0] EVT_MASK_RESET = 3'h0;
  localparam int PEND_INTR_BIT = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// file: logic/flag_mask_bank.sv
// Functional notes
// (RULE1) Every module-level flag bit has one mask bit, where 1 means masked and 0 means unmasked.
// (RULE2) A set mask bit keeps its latched flag from asserting the hardware interrupt.
// (RULE3) Masks are volatile and all read as cleared when management initialization is left.
// (RULE4) The host should mask flags that stay asserted under stable conditions to stop repeated interrupts.
// (RULE5) Byte 31 holds command block two and one done masks in bits 7 and 6, reserved bits 5-3, and faults/state in 2-0.
// (RULE6) Byte 32 holds supply masks in bits 7-4 and temperature masks in bits 3-0, low warn first.
// (RULE7) Byte 33 holds aux-2 masks in bits 7-4 and aux-1 masks in bits 3-0, low warn first.
// (RULE8) Byte 34 holds vendor masks in bits 7-4 and aux-3 masks in bits 3-0, low warn first.
// (RULE9) Byte 35 is reserved and byte 36 holds implementation-specific masks.
// (RULE10) The interrupt is active while any latched flag is set and unmasked, inactive once none is.
//
// The AXI4-Lite slave port is this design's own decision.
module flag_mask_bank (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic managementInitState,
  input wire logic [flag_mask_pkg::FLAG_W-1:0] latchedFlags,
  input wire logic [flag_mask_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [flag_mask_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [flag_mask_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [flag_mask_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic hwIntr,
  output logic evtIrq
);
  import flag_mask_pkg::*;

  logic [7:0] mask_r [0:NUM_SLOTS-1];
  logic [FLAG_W-1:0] maskVec;
  logic [FLAG_W-1:0] activeFlags;
  logic [NUM_SLOTS-1:0] slotPending;
  logic hwIntr_r;
  logic hwIntrNxt;
  logic evtIrq_r;
  logic [EVT_W-1:0] evtStatus_r;
  logic [EVT_W-1:0] evtMask_r;
  logic [EVT_W-1:0] evtSet;
  logic [EVT_W-1:0] evtClr;
  logic awHeld_r;
  logic wHeld_r;
  logic awHeldNxt;
  logic wHeldNxt;
  logic awready_r;
  logic wready_r;
  logic [5:0] awIdx_r;
  logic [7:0] wData_r;
  logic wLane_r;
  logic writeGo;
  logic writeHit;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;
  logic readTake;
  logic [5:0] arIdx;
  logic [7:0] readByte;
  logic readHit;
  logic [7:0] pendView;

  ////////////////////////////////////////////////////////////////////////////
  // mask storage, one byte per slot

  for (genvar s = 0; s < NUM_SLOTS; s++) begin : gSlot
    // (RULE3) clear while initializing
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        mask_r[s] <= MASK_RESET;
      end else if (clkEn) begin
        if (managementInitState) begin
          mask_r[s] <= MASK_RESET;
        // (RULE5) reserved bits dropped
        end else if (writeGo && wLane_r && awIdx_r == SLOT_IDX[s]) begin
          mask_r[s] <= wData_r & SLOT_WMASK[s];
        end
      end
    end
    // (RULE6) (RULE7) (RULE8) bytes in flag order
    assign maskVec[8*s +: 8] = mask_r[s];
    assign slotPending[s] = |(latchedFlags[8*s +: 8] & ~mask_r[s]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // hardware interrupt toward the host

  // (RULE1) one mask bit per flag
  assign activeFlags = latchedFlags & ~maskVec;
  // (RULE10) any unmasked flag
  assign hwIntrNxt = |activeFlags;

  // (RULE2) masked flags excluded
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hwIntr_r <= 1'b0;
    end else if (clkEn) begin
      hwIntr_r <= hwIntrNxt;
    end
  end
  assign hwIntr = hwIntr_r;

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  assign writeGo = awHeld_r && wHeld_r && !bvalid_r;
  assign awHeldNxt = (awHeld_r && !writeGo) || (awvalid && awready_r);
  assign wHeldNxt = (wHeld_r && !writeGo) || (wvalid && wready_r);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      awready_r <= 1'b0;
      awIdx_r <= 6'h00;
    end else if (clkEn) begin
      awHeld_r <= awHeldNxt;
      awready_r <= !awHeldNxt;
      if (awvalid && awready_r) begin
        awIdx_r <= awaddr[7:2];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wHeld_r <= 1'b0;
      wready_r <= 1'b0;
      wData_r <= 8'h00;
      wLane_r <= 1'b0;
    end else if (clkEn) begin
      wHeld_r <= wHeldNxt;
      wready_r <= !wHeldNxt;
      if (wvalid && wready_r) begin
        wData_r <= wdata[7:0];
        wLane_r <= wstrb[0];
      end
    end
  end

  always_comb begin
    writeHit = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (awIdx_r == SLOT_IDX[i]) begin
        writeHit = 1'b1;
      end
    end
    // (RULE9) reserved byte accepted, writes ignored
    if (awIdx_r == IDX_RESERVED || awIdx_r == IDX_EVT_STATUS || awIdx_r == IDX_EVT_MASK ||
        awIdx_r == IDX_PENDING) begin
      writeHit = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (clkEn) begin
      if (writeGo) begin
        bvalid_r <= 1'b1;
        bresp_r <= writeHit ? RESP_OKAY : RESP_DECERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // read channel, answered one cycle after the address is taken

  assign readTake = arvalid && arready_r;
  assign arIdx = araddr[7:2];
  assign pendView = {hwIntr_r, 2'h0, slotPending};

  always_comb begin
    readByte = 8'h00;
    readHit = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (arIdx == SLOT_IDX[i]) begin
        readByte = mask_r[i];
        readHit = 1'b1;
      end
    end
    case (arIdx)
      // (RULE9) reserved byte reads zero
      IDX_RESERVED: begin
        readHit = 1'b1;
      end
      IDX_EVT_STATUS: begin
        readByte = {5'h00, evtStatus_r};
        readHit = 1'b1;
      end
      IDX_EVT_MASK: begin
        readByte = {5'h00, evtMask_r};
        readHit = 1'b1;
      end
      IDX_PENDING: begin
        readByte = pendView;
        readHit = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (clkEn) begin
      if (readTake) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= {24'h00_0000, readByte};
        rresp_r <= readHit ? RESP_OKAY : RESP_DECERR;
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end else if (!rvalid_r) begin
        arready_r <= 1'b1;
      end
    end
  end
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // sticky events; a set in the clearing cycle wins so no edge is lost

  assign evtSet[EVT_INTR_RISE] = hwIntrNxt && !hwIntr_r;
  assign evtSet[EVT_INTR_FALL] = !hwIntrNxt && hwIntr_r;
  assign evtSet[EVT_DECODE_ERR] = (writeGo && !writeHit) || (readTake && !readHit);
  assign evtClr = (writeGo && wLane_r && awIdx_r == IDX_EVT_STATUS) ? wData_r[EVT_W-1:0] : 3'h0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      evtStatus_r <= EVT_STATUS_RESET;
    end else if (clkEn) begin
      evtStatus_r <= (evtStatus_r & ~evtClr) | evtSet;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      evtMask_r <= EVT_MASK_RESET;
    end else if (clkEn && writeGo && wLane_r && awIdx_r == IDX_EVT_MASK) begin
      evtMask_r <= wData_r[EVT_W-1:0];
    end
  end

  // registered for a glitch-free pin, costs one cycle of latency
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      evtIrq_r <= 1'b0;
    end else if (clkEn) begin
      evtIrq_r <= |(evtStatus_r & ~evtMask_r);
    end
  end
  assign evtIrq = evtIrq_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_FULLY_MASKED_QUIET: assert property (  // RULE2
    @(posedge mclk) disable iff (rst)
    clkEn && ((latchedFlags & ~maskVec) == 40'h00_0000_0000) |=> !hwIntr)
    else $error("interrupt raised with every flag masked");

  AST_UNMASKED_RAISES: assert property (  // RULE10
    @(posedge mclk) disable iff (rst)
    clkEn && (|(latchedFlags & ~maskVec)) |=> hwIntr)
    else $error("unmasked flag did not raise interrupt");

  AST_INIT_CLEARS: assert property (  // RULE3
    @(posedge mclk) disable iff (rst)
    clkEn && managementInitState ##1 !managementInitState |-> maskVec == 40'h00_0000_0000)
    else $error("masks not clear on leaving initialization");

  AST_RSVD_BITS_ZERO: assert property (  // RULE5
    @(posedge mclk) disable iff (rst)
    mask_r[0][5:3] == 3'h0)
    else $error("reserved mask bits became set");

  AST_RSVD_BYTE_READ: assert property (  // RULE9
    @(posedge mclk) disable iff (rst)
    clkEn && readTake && arIdx == IDX_RESERVED |=> rvalid && rdata == 32'h0000_0000 && rresp == RESP_OKAY)
    else $error("reserved byte did not read zero");

  AST_SUPPLY_WRITE: assert property (  // RULE6
    @(posedge mclk) disable iff (rst)
    clkEn && writeGo && wLane_r && !managementInitState && awIdx_r == IDX_SUPPLY_TEMP
    |=> mask_r[1] == $past(wData_r))
    else $error("supply and temperature mask byte not stored");

  AST_AUX_PENDING: assert property (  // RULE7
    @(posedge mclk) disable iff (rst)
    clkEn && readTake && arIdx == IDX_PENDING
    |=> rdata[2] == |($past(latchedFlags[23:16]) & ~$past(mask_r[2])))
    else $error("aux group pending view wrong");

  AST_VENDOR_READBACK: assert property (  // RULE8
    @(posedge mclk) disable iff (rst)
    clkEn && readTake && arIdx == IDX_VENDOR_AUX_THREE |=> rdata[7:0] == $past(mask_r[3]))
    else $error("vendor and aux-3 mask readback wrong");

  AST_MASK_PER_BIT: assert property (  // RULE1
    @(posedge mclk) disable iff (rst)
    clkEn && latchedFlags == 40'h00_0000_0001 && maskVec[0] |=> !hwIntr)
    else $error("single masked flag still raised interrupt");

  AST_EVT_RISE_STICKY: assert property (
    @(posedge mclk) disable iff (rst)
    clkEn && !hwIntr && (|(latchedFlags & ~maskVec)) |=> evtStatus_r[EVT_INTR_RISE] ##1 evtIrq || !clkEn
      || evtMask_r[EVT_INTR_RISE] || !evtStatus_r[EVT_INTR_RISE])
    else $error("rise event not recorded");

  AST_INIT_HOLDS_CLEAR: assert property (  // RULE3
    @(posedge mclk) disable iff (rst)
    clkEn && managementInitState |=> maskVec == 40'h00_0000_0000)
    else $error("mask kept a value during initialization");

  AST_CUSTOM_WRITE: assert property (  // RULE9
    @(posedge mclk) disable iff (rst)
    clkEn && writeGo && wLane_r && !managementInitState && awIdx_r == IDX_CUSTOM
    |=> mask_r[4] == $past(wData_r))
    else $error("custom mask byte not stored");

  AST_RSVD_WRITE_IGNORED: assert property (  // RULE9
    @(posedge mclk) disable iff (rst)
    clkEn && writeGo && !managementInitState && awIdx_r == IDX_RESERVED |=> $stable(maskVec))
    else $error("reserved byte write changed a mask");

  AST_CLKEN_FREEZE: assert property (
    @(posedge mclk) disable iff (rst)
    !clkEn |=> $stable(hwIntr) && $stable(evtIrq) && $stable(rvalid) && $stable(bvalid) && $stable(arready))
    else $error("state moved while the clock enable was low");

endmodule

// file: sim/flag_source.sv
// stands in for the flag latches; a flag set here stays set until the bench drops it
module flag_source (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [flag_mask_pkg::FLAG_W-1:0] flagSet,
  output logic [flag_mask_pkg::FLAG_W-1:0] latchedFlags
);
  timeunit 1ns;
  timeprecision 1ps;
  import flag_mask_pkg::*;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      latchedFlags <= '0;
    end else begin
      latchedFlags <= flagSet;
    end
  end
endmodule

// file: sim/module_flag_interrupt_masks_tb_top.sv
module module_flag_interrupt_masks_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flag_mask_pkg::*;
  logic mclk, rst, clkEn, managementInitState, hwIntr, evtIrq;
  logic [7:0] pe;
  logic [FLAG_W-1:0] flagSet, latchedFlags, mk;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [33:0] rdQ [$];
  int miscompares, total_checks, seed, s, i;

  flag_source partner (.mclk(mclk), .rst(rst), .flagSet(flagSet), .latchedFlags(latchedFlags));
  flag_mask_bank uut (.mclk(mclk), .rst(rst), .clkEn(clkEn), .managementInitState(managementInitState),
    .latchedFlags(latchedFlags), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .hwIntr(hwIntr), .evtIrq(evtIrq));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (e !== g) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge mclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {32'h0, er}, {32'h0, bresp});
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    rdQ.push_back({er, 24'h0, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wm(input int sl, input logic [7:0] v);
    wr({SLOT_IDX[sl], 2'b00}, v, RESP_OKAY);
    mk[sl*8 +: 8] = v & SLOT_WMASK[sl];
  endtask

  task automatic chkIntr();
    repeat (3) @(posedge mclk);
    chk("hwIntr", {33'h0, |(flagSet & ~mk)}, {33'h0, hwIntr});
  endtask

  task automatic chkEvt(input logic e);
    repeat (3) @(posedge mclk);
    chk("evtIrq", {33'h0, e}, {33'h0, evtIrq});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // read results are matched in issue order against the notes left by rd
  always @(posedge mclk) begin
    if (rvalid && rready) begin
      if (rdQ.size() == 0) begin
        chk("unexpected read", 34'h0, 34'h3ffffffff);
      end else begin
        chk("rdata", rdQ.pop_front(), {rresp, rdata});
      end
    end
  end

  initial begin
    #50000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    seed = 32'hf89a;
    rst = 1'b1;
    managementInitState = 1'b0;
    clkEn = 1'b1;
    flagSet = '0;
    mk = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (s = 0; s < 6; s++) rd(8'h7c + 8'(4 * s), 8'h00, RESP_OKAY);
    rd(8'h00, 8'h00, RESP_DECERR);
    for (s = 0; s < NUM_SLOTS; s++) wm(s, 8'hff);
    for (s = 0; s < NUM_SLOTS; s++) rd({SLOT_IDX[s], 2'b00}, SLOT_WMASK[s], RESP_OKAY);
    wr(8'h8c, 8'hff, RESP_OKAY);
    rd(8'h8c, 8'h00, RESP_OKAY);
    // masks held clear during initialization, writes dropped
    managementInitState <= 1'b1;
    repeat (2) @(posedge mclk);
    wr(8'h80, 8'h5a, RESP_OKAY);
    rd(8'h80, 8'h00, RESP_OKAY);
    managementInitState <= 1'b0;
    mk = '0;
    for (s = 0; s < NUM_SLOTS; s++) rd({SLOT_IDX[s], 2'b00}, 8'h00, RESP_OKAY);
    // one flag at a time: masked then unmasked; reserved bits stay unmaskable
    for (i = 0; i < FLAG_W; i++) begin
      flagSet <= 40'h1 << i;
      wm(i / 8, 8'h01 << (i % 8));
      chkIntr();
      wm(i / 8, 8'h00);
      chkIntr();
    end
    repeat (12) begin
      flagSet <= 40'({$random(seed), $random(seed)});
      for (s = 0; s < NUM_SLOTS; s++) wm(s, 8'($random(seed)));
      chkIntr();
    end
    // a write without its low byte lane leaves the mask alone
    wstrb <= 4'he;
    wr(8'h80, 8'h5a, RESP_OKAY);
    wstrb <= 4'h1;
    rd(8'h80, mk[15:8], RESP_OKAY);
    // event interrupt: raise, mask, clear
    flagSet <= '0;
    repeat (4) @(posedge mclk);
    wr(8'ha0, 8'h07, RESP_OKAY);
    rd(8'ha0, 8'h00, RESP_OKAY);
    chkEvt(1'b0);
    rd(8'h04, 8'h00, RESP_DECERR);
    chkEvt(1'b1);
    rd(8'ha0, 8'h04, RESP_OKAY);
    wr(8'ha4, 8'h04, RESP_OKAY);
    chkEvt(1'b0);
    wr(8'ha0, 8'h04, RESP_OKAY);
    wr(8'ha4, 8'h00, RESP_OKAY);
    rd(8'ha0, 8'h00, RESP_OKAY);
    chkEvt(1'b0);
    // rise and fall events, pending view, frozen clock enable
    flagSet <= ~mk;
    chkIntr();
    pe = 8'h80;
    for (s = 0; s < NUM_SLOTS; s++) pe[s] = |(~mk[8*s +: 8]);
    rd(8'ha8, pe, RESP_OKAY);
    rd(8'ha0, 8'h01, RESP_OKAY);
    clkEn <= 1'b0;
    flagSet <= '0;
    repeat (4) @(posedge mclk);
    chk("frozen hwIntr", 34'h1, {33'h0, hwIntr});
    clkEn <= 1'b1;
    chkIntr();
    rd(8'ha0, 8'h03, RESP_OKAY);
    chkEvt(1'b1);
    // reset in mid-run clears masks and events
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    mk = '0;
    @(posedge mclk);
    rd(8'ha0, 8'h00, RESP_OKAY);
    for (s = 0; s < NUM_SLOTS; s++) rd({SLOT_IDX[s], 2'b00}, 8'h00, RESP_OKAY);
    chkEvt(1'b0);
    repeat (4) @(posedge mclk);
    report_and_stop();
  end
endmodule
